// ### core/agcnv_params.svh
/*
 holds offsets, field positions, reset values and timing counts of the add-on
 general control/status register block. assumes inclusion by bare name.
*/
`ifndef AGCNV_PARAMS_SVH
`define AGCNV_PARAMS_SVH
// ============================================================
// register map
`define AGCNV_REG_OFFSET      6'h3C
`define AGCNV_RESET_PCI_MSTR  32'h000000F4
`define AGCNV_RESET_ADD_MSTR  32'h00000034
// ============================================================
// field positions
`define AGCNV_BIT_GO          31
`define AGCNV_BIT_CMD_HI      30
`define AGCNV_BIT_CMD_LO      29
`define AGCNV_BIT_XCNT_EN     28
`define AGCNV_BIT_MBX_RST     27
`define AGCNV_BIT_A2P_RST     26
`define AGCNV_BIT_P2A_RST     25
`define AGCNV_NV_MSB          23
`define AGCNV_NV_LSB          16
`define AGCNV_BIST_MSB        15
`define AGCNV_BIST_LSB        12
// ============================================================
// timing of one external memory cycle
`define AGCNV_CLK_MHZ         25
`define AGCNV_NV_CYCLE_NS     200
`define AGCNV_NV_CYCLE_CLKS   ((`AGCNV_NV_CYCLE_NS * `AGCNV_CLK_MHZ + 999) / 1000)
// strap capture point and last count of the power-up image window
`define AGCNV_STRAP_TAKE      3'h4
`define AGCNV_STRAP_LAST      3'h7
`endif

// ### core/agcnv_pkg.sv
/*
 holds the types of the add-on general control/status block.
 assumes the params header is compiled alongside.
*/
package agcnv_pkg;
	// ============================================================
	// non-volatile access commands
	typedef enum logic [1:0] {
		AGCNV_CMD_LOAD_LO,
		AGCNV_CMD_LOAD_HI,
		AGCNV_CMD_WRITE,
		AGCNV_CMD_READ
	} agcnv_cmd_t;
	// sequencer states
	typedef enum logic [1:0] {
		AGCNV_ST_IDLE,
		AGCNV_ST_WRITE,
		AGCNV_ST_READ,
		AGCNV_ST_DONE
	} agcnv_state_t;
endpackage

// ### core/agcnv_strap_sync.sv
/*
 three-stage synchroniser for a pin level; a change is taken once stages two
 and three agree. assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module agcnv_strap_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	// clock and reset
	input  wire logic sys_clk_i,
	input  wire logic reset_n_i,
	// level in and out
	input  wire logic pin_i,
	output logic      level_o
);
	logic [2:0] stage_q;
	logic [2:0] stage_d;
	logic       level_q;
	logic       level_d;
	// ============================================================
	// next values
	always_comb begin
		stage_d = {stage_q[1:0], pin_i};
		level_d = level_q;
		if (stage_q[2] == stage_q[1]) begin
			level_d = stage_q[2];
		end
	end
	// ============================================================
	// registers
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			stage_q <= {3{RESET_VAL}};
			level_q <= RESET_VAL;
		end else begin
			stage_q <= stage_d;
			level_q <= level_d;
		end
	end
	assign level_o = level_q;
endmodule

// ### core/agcnv_top.sv
/*
 add-on general control/status register with a byte sequencer for the optional
 external non-volatile memory. assumes a synchronous add-on register port with
 one-cycle read and write strobes, fifo flags and transfer-count flags from
 neighbouring logic, and an external memory that answers within a fixed cycle.
*/
`timescale 1ns/1ps
`include "agcnv_params.svh"
// Contract
// R1: register powers up 0xF4 with PCI mastering, 0x34 with add-on mastering.
// R2: writes reset mailbox flags and either FIFO's flags, nothing else touched; code also loads transfer-count enable and, when idle, the byte field.
// R3: full, empty and four-plus flags of both FIFOs are readable.
// R4: software loads low address, high address, then data, in that order.
// R5: software writes go as one to start; zero leaves the interface idle.
// R6: software polls go/busy to zero before each next step.
// R7: with go set, 00 low address, 01 high address, 10 write, 11 read.
// R8: go reads one while busy, zero when ready.
// R9: memory port is shared with PCI side; no arbitration here.
// R10: software on both sides keeps their memory accesses apart.
// R11: byte field carries address or data; read returns memory data there.
// R12: mailbox reset bit pulses mailbox flags empty and reads zero.
// R13: FIFO reset bits pulse that direction's flags reset and read zero.
// R14: busy holds from write or read start until the memory cycle ends.
module agcnv_top #(
	parameter int NV_CYCLE_CLKS = `AGCNV_NV_CYCLE_CLKS,
	parameter int NV_ADDR_W     = 16
) (
	// clock and reset
	input  wire logic                 sys_clk_i,
	input  wire logic                 reset_n_i,
	// mastering strap pin, high for add-on initiated mastering
	input  wire logic                 addon_master_strap_i,
	// add-on register port
	input  wire logic [5:0]           reg_addr_i,
	input  wire logic                 reg_wr_i,
	input  wire logic                 reg_rd_i,
	input  wire logic [31:0]          reg_wdata_i,
	output logic      [31:0]          reg_rdata_o,
	// fifo and count status in
	input  wire logic                 a2p_full_i,
	input  wire logic                 a2p_four_plus_i,
	input  wire logic                 a2p_empty_i,
	input  wire logic                 p2a_full_i,
	input  wire logic                 p2a_four_plus_i,
	input  wire logic                 p2a_empty_i,
	input  wire logic                 wr_count_zero_i,
	input  wire logic                 rd_count_zero_i,
	input  wire logic [3:0]           bist_code_i,
	// flag reset pulses and transfer-count enable out
	output logic                      mbx_flag_reset_o,
	output logic                      a2p_flag_reset_o,
	output logic                      p2a_flag_reset_o,
	output logic                      xfer_count_en_o,
	// external non-volatile memory
	output logic [NV_ADDR_W-1:0]      nv_addr_o,
	output logic [7:0]                nv_wdata_o,
	input  wire logic [7:0]           nv_rdata_i,
	output logic                      nv_wr_o,
	output logic                      nv_rd_o,
	output logic                      nv_busy_o
);
	// elaboration check: eight-bit cycle counter, two-byte address
	if (NV_CYCLE_CLKS < 1 || NV_CYCLE_CLKS > 255 || NV_ADDR_W != 16) begin : g_param_check
		$error("agcnv_top: unsupported parameter values");
	end
	// ============================================================
	// strap capture after reset release
	logic strap_lvl;
	logic strap_done_q;
	logic strap_done_d;
	logic add_mstr_q;
	logic add_mstr_d;
	agcnv_strap_sync #(.RESET_VAL(1'b0)) u_strap (
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.pin_i     (addon_master_strap_i),
		.level_o   (strap_lvl)
	);
	logic [2:0] strap_wait_q;
	logic [2:0] strap_wait_d;
	always_comb begin
		strap_wait_d = strap_wait_q;
		strap_done_d = strap_done_q;
		add_mstr_d   = add_mstr_q;
		// counter runs on past capture so the image is shown with the captured mode
		if (strap_wait_q != `AGCNV_STRAP_LAST) begin
			strap_wait_d = strap_wait_q + 3'h1;
		end
		if (!strap_done_q && strap_wait_q == `AGCNV_STRAP_TAKE) begin
			strap_done_d = 1'b1;
			add_mstr_d   = strap_lvl;
		end
	end
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			strap_wait_q <= 3'h0;
			strap_done_q <= 1'b0;
			add_mstr_q   <= 1'b0;
		end else begin
			strap_wait_q <= strap_wait_d;
			strap_done_q <= strap_done_d;
			add_mstr_q   <= add_mstr_d;
		end
	end
	// ============================================================
	// read and write decode
	logic wr_hit;
	logic rd_hit;
	always_comb begin
		wr_hit = 1'b0;
		rd_hit = 1'b0;
		if (reg_addr_i == `AGCNV_REG_OFFSET) begin
			wr_hit = reg_wr_i;
			rd_hit = reg_rd_i;
		end
	end
	// ============================================================
	// control state and sequencer
	agcnv_pkg::agcnv_state_t state_q;
	agcnv_pkg::agcnv_state_t state_d;
	agcnv_pkg::agcnv_cmd_t   cmd;
	logic [7:0]           cnt_q;
	logic [7:0]           cnt_d;
	logic [7:0]           addr_lo_q;
	logic [7:0]           addr_lo_d;
	logic [7:0]           addr_hi_q;
	logic [7:0]           addr_hi_d;
	logic [7:0]           nv_byte_q;
	logic [7:0]           nv_byte_d;
	logic                 xcnt_q;
	logic                 xcnt_d;
	logic                 mbx_rst_q;
	logic                 mbx_rst_d;
	logic                 a2p_rst_q;
	logic                 a2p_rst_d;
	logic                 p2a_rst_q;
	logic                 p2a_rst_d;
	logic                 busy;
	assign cmd  = agcnv_pkg::agcnv_cmd_t'(reg_wdata_i[`AGCNV_BIT_CMD_HI:`AGCNV_BIT_CMD_LO]);
	assign busy = (state_q != agcnv_pkg::AGCNV_ST_IDLE);
	always_comb begin
		state_d   = state_q;
		cnt_d     = cnt_q;
		addr_lo_d = addr_lo_q;
		addr_hi_d = addr_hi_q;
		nv_byte_d = nv_byte_q;
		xcnt_d    = xcnt_q;
		mbx_rst_d = wr_hit && reg_wdata_i[`AGCNV_BIT_MBX_RST]; // R12
		a2p_rst_d = wr_hit && reg_wdata_i[`AGCNV_BIT_A2P_RST]; // R2 R13
		p2a_rst_d = wr_hit && reg_wdata_i[`AGCNV_BIT_P2A_RST]; // R2 R13
		if (!strap_done_q && strap_done_d) begin
			xcnt_d  = 1'b0;
		end
		if (wr_hit) begin
			xcnt_d = reg_wdata_i[`AGCNV_BIT_XCNT_EN];
			if (!busy) begin
				nv_byte_d = reg_wdata_i[`AGCNV_NV_MSB:`AGCNV_NV_LSB]; // R11
			end
		end
		case (state_q)
			agcnv_pkg::AGCNV_ST_IDLE: begin
				if (wr_hit && reg_wdata_i[`AGCNV_BIT_GO]) begin // R7
					case (cmd)
						agcnv_pkg::AGCNV_CMD_LOAD_LO: begin
							addr_lo_d = reg_wdata_i[`AGCNV_NV_MSB:`AGCNV_NV_LSB];
						end
						agcnv_pkg::AGCNV_CMD_LOAD_HI: begin
							addr_hi_d = reg_wdata_i[`AGCNV_NV_MSB:`AGCNV_NV_LSB];
						end
						agcnv_pkg::AGCNV_CMD_WRITE: begin
							state_d = agcnv_pkg::AGCNV_ST_WRITE; // R14
							cnt_d   = 8'(NV_CYCLE_CLKS);
						end
						default: begin
							state_d = agcnv_pkg::AGCNV_ST_READ; // R14
							cnt_d   = 8'(NV_CYCLE_CLKS);
						end
					endcase
				end
			end
			agcnv_pkg::AGCNV_ST_WRITE, agcnv_pkg::AGCNV_ST_READ: begin
				cnt_d = cnt_q - 8'h01;
				if (cnt_q == 8'h01) begin
					if (state_q == agcnv_pkg::AGCNV_ST_READ) begin
						nv_byte_d = nv_rdata_i; // R11
					end
					state_d = agcnv_pkg::AGCNV_ST_DONE;
				end
			end
			default: begin
				state_d = agcnv_pkg::AGCNV_ST_IDLE; // R14
			end
		endcase
	end
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q   <= agcnv_pkg::AGCNV_ST_IDLE;
			cnt_q     <= 8'h00;
			addr_lo_q <= 8'h00;
			addr_hi_q <= 8'h00;
			nv_byte_q <= 8'h00;
			xcnt_q    <= 1'b0;
			mbx_rst_q <= 1'b0;
			a2p_rst_q <= 1'b0;
			p2a_rst_q <= 1'b0;
		end else begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			addr_lo_q <= addr_lo_d;
			addr_hi_q <= addr_hi_d;
			nv_byte_q <= nv_byte_d;
			xcnt_q    <= xcnt_d;
			mbx_rst_q <= mbx_rst_d;
			a2p_rst_q <= a2p_rst_d;
			p2a_rst_q <= p2a_rst_d;
		end
	end
	// ============================================================
	// read data; power-up image depends on the mastering mode
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [31:0] status_w;
	logic [31:0] reset_img;
	assign reset_img = add_mstr_q ? `AGCNV_RESET_ADD_MSTR : `AGCNV_RESET_PCI_MSTR; // R1
	always_comb begin
		status_w = 32'h00000000;
		status_w[`AGCNV_BIT_GO]     = busy; // R8
		status_w[`AGCNV_BIT_XCNT_EN] = xcnt_q;
		status_w[`AGCNV_NV_MSB:`AGCNV_NV_LSB] = nv_byte_q; // R11
		status_w[`AGCNV_BIST_MSB:`AGCNV_BIST_LSB] = bist_code_i;
		status_w[7] = add_mstr_q && wr_count_zero_i;
		status_w[6] = add_mstr_q && rd_count_zero_i;
		// R3
		status_w[5:0] = {p2a_empty_i, p2a_four_plus_i, p2a_full_i,
			a2p_empty_i, a2p_four_plus_i, a2p_full_i};
		if (strap_wait_q != `AGCNV_STRAP_LAST) begin
			status_w = reset_img;
			status_w[`AGCNV_BIT_GO] = busy; // R8
		end
		rdata_d = rdata_q;
		if (rd_hit) begin
			rdata_d = status_w;
		end else if (reg_rd_i) begin
			rdata_d = 32'h00000000;
		end
	end
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_q <= 32'h00000000;
		end else begin
			rdata_q <= rdata_d;
		end
	end
	// ============================================================
	// outputs; memory port shared with PCI side, no arbitration  R9
	assign reg_rdata_o      = rdata_q;
	assign mbx_flag_reset_o = mbx_rst_q;
	assign a2p_flag_reset_o = a2p_rst_q;
	assign p2a_flag_reset_o = p2a_rst_q;
	assign xfer_count_en_o  = xcnt_q;
	assign nv_addr_o        = {addr_hi_q, addr_lo_q};
	assign nv_wdata_o       = nv_byte_q;
	assign nv_wr_o          = (state_q == agcnv_pkg::AGCNV_ST_WRITE);
	assign nv_rd_o          = (state_q == agcnv_pkg::AGCNV_ST_READ);
	assign nv_busy_o        = busy;
endmodule

// ### verification/agcnv_nv_mem.sv
/*
 model of the external byte memory.
 assumes strobes and address come from the block on sys_clk_i.
*/
`timescale 1ns/1ps
module agcnv_nv_mem #(
	parameter int LAT = 1
) (
	input  wire logic        sys_clk_i,
	input  wire logic [15:0] nv_addr_i,
	input  wire logic [7:0]  nv_wdata_i,
	input  wire logic        nv_wr_i,
	input  wire logic        nv_rd_i,
	output logic      [7:0]  nv_rdata_o
);
	logic [7:0] mem [logic [15:0]];
	logic [7:0] last = 8'h00;
	int         age  = 0;
	always @(posedge sys_clk_i) begin
		age <= nv_rd_i ? age + 1 : 0;
		if (nv_wr_i) begin
			mem[nv_addr_i] = nv_wdata_i;
		end
		last <= nv_rdata_o;
	end
	// data only late in a read, else a changing pattern
	assign nv_rdata_o = (nv_rd_i && age >= LAT && mem.exists(nv_addr_i)) ?
		mem[nv_addr_i] : ~last;
endmodule

// ### verification/agcnv_top_chk.sv
/*
 port checker of the control/status block.
 assumes a bind to agcnv_top, one clock and an active-low reset.
*/
`timescale 1ns/1ps
module agcnv_top_chk (
	// clock and reset
	input wire logic        sys_clk_i,
	input wire logic        reset_n_i,
	// register port
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [5:0]  reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic [31:0] reg_rdata_o,
	// reset pulses
	input wire logic        mbx_flag_reset_o,
	input wire logic        a2p_flag_reset_o,
	input wire logic        p2a_flag_reset_o,
	// memory strobes
	input wire logic        nv_wr_o,
	input wire logic        nv_rd_o,
	input wire logic        nv_busy_o
);
	// ====
	// write decode
	logic hit;
	assign hit = reg_wr_i && reg_addr_i == 6'h3C;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	// ====
	// properties
	AST_WR_GO: assert property (hit && reg_wdata_i[31:29] == 3'h6 && !nv_busy_o |=> nv_wr_o && nv_busy_o)
		else $error("write cycle not started");
	AST_RD_GO: assert property (hit && reg_wdata_i[31:29] == 3'h7 && !nv_busy_o |=> nv_rd_o && nv_busy_o)
		else $error("read cycle not started");
	AST_GO_LOW: assert property (hit && !reg_wdata_i[31] && !nv_busy_o |=> !nv_busy_o)
		else $error("busy without go");
	AST_MBX: assert property (1'b1 |=> mbx_flag_reset_o == $past(hit && reg_wdata_i[27]))
		else $error("mailbox reset pulse wrong");
	AST_A2P: assert property (1'b1 |=> a2p_flag_reset_o == $past(hit && reg_wdata_i[26]))
		else $error("outbound reset pulse wrong");
	AST_P2A: assert property (1'b1 |=> p2a_flag_reset_o == $past(hit && reg_wdata_i[25]))
		else $error("inbound reset pulse wrong");
	AST_WR_END: assert property ($fell(nv_wr_o) |-> nv_busy_o ##1 !nv_busy_o)
		else $error("busy not held to write end");
	AST_RD_END: assert property ($fell(nv_rd_o) |-> nv_busy_o ##1 !nv_busy_o)
		else $error("busy not held to read end");
	AST_BUSY_BIT: assert property (reg_rd_i && reg_addr_i == 6'h3C |=> reg_rdata_o[31] == $past(nv_busy_o))
		else $error("go bit not busy status");
	AST_WO_ZERO: assert property (reg_rd_i |=> reg_rdata_o[27:25] == 3'h0)
		else $error("reset bits read nonzero");
endmodule

// ### verification/test_addon_general_ctrl_nv_access.sv
/*
 self-checking bench of the control/status block.
 assumes agcnv_top, the memory model and the checker are compiled.
*/
`timescale 1ns/1ps
`include "agcnv_params.svh"
module test_addon_general_ctrl_nv_access;
	localparam int NV = 4;
	logic        sys_clk = 1'b0, reset_n = 1'b0, strap = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [5:0]  addr = 6'h3C, fl = 6'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0]  bist = 4'h0;
	logic [1:0]  cz = 2'h0;
	logic        mbx_rst, a2p_rst, p2a_rst, xen, nv_wr, nv_rd, busy;
	logic [15:0] nv_addr;
	logic [7:0]  nv_wd, nv_rdd, lo, hi, dat;
	int          miscompares = 0, n_checks = 0, cycles = 0, i, seed = 32'h5AC284BB;
	always #20 sys_clk = ~sys_clk;
	agcnv_top #(.NV_CYCLE_CLKS(NV)) DUT (
		.sys_clk_i(sys_clk), .reset_n_i(reset_n), .addon_master_strap_i(strap),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
		.reg_rdata_o(rdata), .a2p_full_i(fl[0]), .a2p_four_plus_i(fl[1]),
		.a2p_empty_i(fl[2]), .p2a_full_i(fl[3]), .p2a_four_plus_i(fl[4]),
		.p2a_empty_i(fl[5]), .wr_count_zero_i(cz[1]), .rd_count_zero_i(cz[0]),
		.bist_code_i(bist), .mbx_flag_reset_o(mbx_rst), .a2p_flag_reset_o(a2p_rst),
		.p2a_flag_reset_o(p2a_rst), .xfer_count_en_o(xen), .nv_addr_o(nv_addr),
		.nv_wdata_o(nv_wd), .nv_rdata_i(nv_rdd), .nv_wr_o(nv_wr), .nv_rd_o(nv_rd),
		.nv_busy_o(busy)
	);
	agcnv_nv_mem #(.LAT(2)) u_mem (
		.sys_clk_i(sys_clk), .nv_addr_i(nv_addr), .nv_wdata_i(nv_wd),
		.nv_wr_i(nv_wr), .nv_rd_i(nv_rd), .nv_rdata_o(nv_rdd)
	);
	// ====
	// tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run;
		if (miscompares == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(negedge sys_clk);
		addr = a;
		wr = w;
		rd = !w;
		wdata = d;
		@(negedge sys_clk);
		wr = 1'b0;
		rd = 1'b0;
	endtask
	task automatic nv_step(input logic [2:0] ctl, input logic [7:0] b, input int exp_busy);
		int n;
		n = 0;
		acc(1'b1, 6'h3C, {ctl, 5'h00, b, 16'h0000});
		while (busy === 1'b1 && n < 300) begin
			@(negedge sys_clk);
			n++;
		end
		chk("busy_cycles", n, exp_busy);
		acc(1'b0, 6'h3C, 32'h0);
		chk("go_busy_bit", rdata[31], 1'b0);
	endtask
	// count-zero bits show only with add-on mastering, the mode left by the reset loop
	function automatic logic [31:0] status_exp(logic [3:0] b, logic [1:0] c, logic [5:0] f);
		return {16'h0000, b, 4'h0, c, f};
	endfunction
	// ====
	// sequence
	initial begin
		for (i = 0; i < 2; i++) begin
			strap = i[0];
			reset_n = 1'b0;
			repeat (4) @(negedge sys_clk);
			reset_n = 1'b1;
			repeat (4) @(negedge sys_clk);
			acc(1'b0, 6'h3C, 32'h0);
			chk("power_up", rdata, i ? `AGCNV_RESET_ADD_MSTR : `AGCNV_RESET_PCI_MSTR);
		end
		for (i = 0; i < 6; i++) begin
			fl = (i == 0) ? 6'h3F : 6'($random(seed));
			bist = 4'($random(seed));
			cz = 2'($random(seed));
			acc(1'b0, 6'h3C, 32'h0);
			chk("status", rdata & 32'hFFFF, status_exp(bist, cz, fl));
		end
		acc(1'b0, 6'h38, 32'h0);
		chk("unmapped", rdata, 32'h0);
		acc(1'b1, 6'h38, 32'hE0000000);
		chk("unmapped_go", busy, 1'b0);
		for (i = 0; i < 3; i++) begin
			lo = 8'($random(seed));
			hi = 8'($random(seed));
			dat = (i == 0) ? 8'hFF : 8'($random(seed));
			nv_step(3'h4, lo, 0);
			nv_step(3'h5, hi, 0);
			chk("nv_addr", nv_addr, {hi, lo});
			nv_step(3'h6, dat, NV + 1);
			chk("nv_wdata", nv_wd, dat);
			nv_step(3'h3, ~lo, 0);
			chk("addr_go_low", nv_addr, {hi, lo});
			acc(1'b1, 6'h3C, {3'h7, 29'h0});
			acc(1'b0, 6'h3C, 32'h0);
			chk("busy_on_read", rdata[31], 1'b1);
			acc(1'b1, 6'h3C, {3'h4, 5'h00, ~lo, 16'h0000});
			repeat (8) if (rdata[31] !== 1'b0) acc(1'b0, 6'h3C, 32'h0);
			chk("read_ready", rdata[31], 1'b0);
			chk("read_byte", rdata[23:16], dat);
			chk("addr_refused", nv_addr, {hi, lo});
		end
		for (i = 25; i < 28; i++) begin
			acc(1'b1, 6'h3C, (32'h1 << i) | 32'h10000000);
			chk("flag_reset", {mbx_rst, a2p_rst, p2a_rst}, 3'h1 << (i - 25));
			@(negedge sys_clk);
			chk("flag_pulse_end", {mbx_rst, a2p_rst, p2a_rst}, 3'h0);
			chk("other_state", {busy, xen, nv_addr}, {1'b0, 1'b1, hi, lo});
		end
		acc(1'b0, 6'h3C, 32'h0);
		chk("write_only_zero", rdata[28:25], 4'h8);
		complete_run();
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			complete_run();
		end
	end
endmodule
bind agcnv_top agcnv_top_chk u_chk (.*);
